// ==== design/acr_top.sv ====
// Converter control, status and result registers behind an AXI4-Lite slave.
`timescale 1ns/1ps
`default_nettype none
module acr_top (
	// Clock and reset
	input wire logic CORE_CLK_I,
	input wire logic ARST_N_I,
	// AXI4-Lite write address and data
	input wire logic AWVALID_I,
	output logic AWREADY_O,
	input wire logic [acr_pkg::ADDR_W-1:0] AWADDR_I,
	input wire logic WVALID_I,
	output logic WREADY_O,
	input wire logic [31:0] WDATA_I,
	input wire logic [3:0] WSTRB_I,
	// AXI4-Lite write response
	output logic BVALID_O,
	input wire logic BREADY_I,
	output logic [1:0] BRESP_O,
	// AXI4-Lite read
	input wire logic ARVALID_I,
	output logic ARREADY_O,
	input wire logic [acr_pkg::ADDR_W-1:0] ARADDR_I,
	output logic RVALID_O,
	input wire logic RREADY_I,
	output logic [31:0] RDATA_O,
	output logic [1:0] RRESP_O,
	// Processor side
	input wire logic GLOBAL_IRQ_EN_I,
	input wire logic IRQ_ACK_I,
	input wire logic [6:0] TRIG_FLAGS_I,
	output logic IRQ_O,
	// Analog core
	input wire logic [9:0] ANA_RESULT_I,
	output acr_pkg::acr_ana_ctrl_t ANA_O
);
	import acr_pkg::*;

	// Register state.
	logic enable_ff;
	logic auto_ff;
	logic flag_ff;
	logic irq_en_ff;
	logic [2:0] prescale_ff;
	logic [1:0] ref_ff;
	logic left_ff;
	logic [3:0] chan_ff;
	logic [2:0] trig_src_ff;
	logic [9:0] result_ff;
	logic lock_ff;
	// Conversion state.
	typedef enum logic [1:0] {
		ACR_IDLE = 2'b01,
		ACR_CONV = 2'b10
	} acr_state_t;
	acr_state_t state_ff;
	acr_state_t nxt_state;
	logic init_pend_ff;
	logic first_ff;
	logic [4:0] cyc_ff;
	logic [1:0] act_ref_ff;
	logic [3:0] act_chan_ff;
	// Bus state.
	logic awready_ff;
	logic wready_ff;
	logic [7:0] aw_idx_ff;
	logic [7:0] w_byte_ff;
	logic w_lane_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic arready_ff;
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;
	logic irq_ff;
	acr_ana_ctrl_t ana_ff;

	logic tick;
	logic conv_clk;
	logic trig_edge;
	logic do_write;
	logic wr_ctrl_a;
	logic wr_ctrl_b;
	logic wr_sel;
	logic do_read;
	logic [7:0] rd_idx;
	logic busy;
	logic done;
	logic start;
	logic write_start;
	logic free_restart;
	logic [4:0] conv_len;
	logic [15:0] shown;

	// Maps a byte address to a register index.
	function automatic logic [7:0] idx_of(input logic [ADDR_W-1:0] a);
		return a[9:2];
	endfunction

	// Presents the stored result in the selected layout.
	function automatic logic [15:0] present(input logic [9:0] r, input logic left);
		logic [15:0] v;
		v = {6'h00, r};
		if (left) begin
			v = {r, 6'h00};
		end
		return v;
	endfunction

	function automatic logic mapped(input logic [7:0] i);
		return (i == IDX_RES_LOW) || (i == IDX_RES_HIGH) || (i == IDX_CTRL_A) ||
			(i == IDX_CTRL_B) || (i == IDX_SELECT);
	endfunction

	acr_prescale u_prescale (
		.clk_i(CORE_CLK_I),
		.arst_n_i(ARST_N_I),
		.run_i(enable_ff),
		.code_i(prescale_ff),
		.tick_o(tick),
		.conv_clk_o(conv_clk)
	);

	acr_trig_sel u_trig (
		.clk_i(CORE_CLK_I),
		.arst_n_i(ARST_N_I),
		.auto_i(auto_ff),
		.src_i(trig_src_ff),
		.flags_i(TRIG_FLAGS_I),
		.edge_o(trig_edge)
	);

	// Write channel: address and data are held until both are present.
	assign do_write = !awready_ff && !wready_ff && !bvalid_ff;
	assign wr_ctrl_a = do_write && w_lane_ff && (aw_idx_ff == IDX_CTRL_A);
	assign wr_ctrl_b = do_write && w_lane_ff && (aw_idx_ff == IDX_CTRL_B);
	assign wr_sel = do_write && w_lane_ff && (aw_idx_ff == IDX_SELECT);

	always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			awready_ff <= 1'b1;
			aw_idx_ff <= 8'h00;
		end else if (AWVALID_I && awready_ff) begin
			awready_ff <= 1'b0;
			aw_idx_ff <= idx_of(AWADDR_I);
		end else if (do_write) begin
			awready_ff <= 1'b1;
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			wready_ff <= 1'b1;
			w_byte_ff <= 8'h00;
			w_lane_ff <= 1'b0;
		end else if (WVALID_I && wready_ff) begin
			wready_ff <= 1'b0;
			w_byte_ff <= WDATA_I[7:0];
			w_lane_ff <= WSTRB_I[0];
		end else if (do_write) begin
			wready_ff <= 1'b1;
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
		end else if (do_write) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= mapped(aw_idx_ff) ? RESP_OKAY : RESP_SLVERR;
		end else if (BREADY_I) begin
			bvalid_ff <= 1'b0;
		end
	end

	// Control register A and selection registers.
	always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			enable_ff <= 1'b0;
			auto_ff <= 1'b0;
			irq_en_ff <= 1'b0;
			prescale_ff <= 3'h0;
		end else if (wr_ctrl_a) begin
			enable_ff <= w_byte_ff[CA_ENABLE];
			auto_ff <= w_byte_ff[CA_AUTO];
			irq_en_ff <= w_byte_ff[CA_IRQ_EN];
			prescale_ff <= w_byte_ff[CA_PS_LSB +: 3];
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			ref_ff <= 2'h0;
			left_ff <= 1'b0;
			chan_ff <= 4'h0;
			trig_src_ff <= 3'h0;
		end else begin
			if (wr_sel) begin
				ref_ff <= w_byte_ff[SEL_REF_LSB +: 2];
				left_ff <= w_byte_ff[SEL_LEFT];
				chan_ff <= w_byte_ff[SEL_CHAN_LSB +: 4];
			end
			if (wr_ctrl_b) begin
				trig_src_ff <= w_byte_ff[CB_TRIG_LSB +: 3];
			end
		end
	end

	// Conversion sequencing.
	assign busy = (state_ff == ACR_CONV);
	assign conv_len = first_ff ? CONV_FIRST_CYC : CONV_NORMAL_CYC;
	assign done = busy && enable_ff && tick && (cyc_ff == conv_len - 5'd1);
	assign write_start = wr_ctrl_a && w_byte_ff[CA_START] && w_byte_ff[CA_ENABLE];
	assign free_restart = done && auto_ff && (trig_src_ff == TRIG_FREE_RUN) && !(wr_ctrl_a && !w_byte_ff[CA_ENABLE]);
	assign start = (!busy && enable_ff && (write_start || trig_edge)) ||
		(!busy && write_start) || free_restart;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ACR_IDLE: begin
				if (start) begin
					nxt_state = ACR_CONV;
				end
			end
			ACR_CONV: begin
				if (wr_ctrl_a && !w_byte_ff[CA_ENABLE]) begin
					nxt_state = ACR_IDLE;
				end else if (done && !free_restart) begin
					nxt_state = ACR_IDLE;
				end
			end
			default: begin
				nxt_state = ACR_IDLE;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			state_ff <= ACR_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			init_pend_ff <= 1'b0;
			first_ff <= 1'b0;
			cyc_ff <= 5'd0;
		end else begin
			if (start) begin
				first_ff <= init_pend_ff || (wr_ctrl_a && w_byte_ff[CA_ENABLE] && !enable_ff);
				cyc_ff <= 5'd0;
				init_pend_ff <= 1'b0;
			end else begin
				if (wr_ctrl_a && w_byte_ff[CA_ENABLE] && !enable_ff) begin
					init_pend_ff <= 1'b1;
				end
				if (busy && tick) begin
					cyc_ff <= cyc_ff + 5'd1;
				end
			end
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			act_ref_ff <= 2'h0;
			act_chan_ff <= 4'h0;
		end else if (!busy || done) begin
			act_ref_ff <= wr_sel ? w_byte_ff[SEL_REF_LSB +: 2] : ref_ff;
			act_chan_ff <= wr_sel ? w_byte_ff[SEL_CHAN_LSB +: 4] : chan_ff;
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			result_ff <= 10'h000;
		end else if (done && !lock_ff) begin
			result_ff <= ANA_RESULT_I;
		end
	end

	// write one clears; vector clears; set wins
	always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			flag_ff <= 1'b0;
		end else if (done) begin
			flag_ff <= 1'b1;
		end else if ((wr_ctrl_a && w_byte_ff[CA_FLAG]) || IRQ_ACK_I) begin
			flag_ff <= 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= flag_ff && irq_en_ff && GLOBAL_IRQ_EN_I;
		end
	end

	// temperature sensor; select codes pass to core
	always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			ana_ff <= '0;
		end else begin
			ana_ff.power <= wr_ctrl_a ? w_byte_ff[CA_ENABLE] : enable_ff;
			ana_ff.temp_sensor_on <= (act_chan_ff == CHAN_TEMP);
			ana_ff.reference_select <= act_ref_ff;
			ana_ff.channel_select <= act_chan_ff;
			ana_ff.sample <= start;
			ana_ff.conv_clk <= conv_clk;
		end
	end

	// Read channel with one cycle latency.
	assign do_read = ARVALID_I && arready_ff;
	assign rd_idx = idx_of(ARADDR_I);
	assign shown = present(result_ff, left_ff);

	// lock on low read, release on high read
	always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			lock_ff <= 1'b0;
		end else if (do_read && rd_idx == IDX_RES_LOW) begin
			lock_ff <= 1'b1;
		end else if (do_read && rd_idx == IDX_RES_HIGH) begin
			lock_ff <= 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			arready_ff <= 1'b1;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= RESP_OKAY;
		end else if (do_read) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b1;
			rresp_ff <= mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
			case (rd_idx)
				// live layout; high byte next index
				IDX_RES_LOW: begin
					rdata_ff <= {24'h00_0000, shown[7:0]};
				end
				IDX_RES_HIGH: begin
					rdata_ff <= {24'h00_0000, shown[15:8]};
				end
				IDX_CTRL_A: begin
					rdata_ff <= {24'h00_0000, enable_ff, busy, auto_ff, flag_ff, irq_en_ff, prescale_ff};
				end
				IDX_CTRL_B: begin
					rdata_ff <= {29'h0000_0000, trig_src_ff};
				end
				IDX_SELECT: begin
					rdata_ff <= {24'h00_0000, ref_ff, left_ff, 1'b0, chan_ff};
				end
				default: begin
					rdata_ff <= {24'h00_0000, RESET_BYTE};
				end
			endcase
		end else if (rvalid_ff && RREADY_I) begin
			rvalid_ff <= 1'b0;
			arready_ff <= 1'b1;
		end
	end

	assign AWREADY_O = awready_ff;
	assign WREADY_O = wready_ff;
	assign BVALID_O = bvalid_ff;
	assign BRESP_O = bresp_ff;
	assign ARREADY_O = arready_ff;
	assign RVALID_O = rvalid_ff;
	assign RDATA_O = rdata_ff;
	assign RRESP_O = rresp_ff;
	assign IRQ_O = irq_ff;
	assign ANA_O = ana_ff;
endmodule
`default_nettype wire

// ==== design/acr_pkg.sv ====
// Constants, types and helpers shared by the converter control block.
// Summary of operation
// - Channel code 1000 routes the temperature sensor to the converter and powers it.
// - Reference and channel rewrites take effect only after the running conversion completes.
// - Reference code 00 external pin, 01 analog supply, 11 bandgap, 10 reserved.
// - Channel codes 0000-0111 external inputs, 1000 temperature sensor, 1110 bandgap, 1111 ground, others reserved.
// - Changing left adjust alters result presentation immediately, even mid conversion.
// - Enable bit powers the converter; clearing it aborts a running conversion.
// - Writing one to start begins a conversion; free running needs only the first.
// - First conversion after enabling lasts 25 converter clocks instead of 13.
// - Start bit reads one while converting, zero after; writing zero does nothing.
// - With auto trigger on, each rising trigger edge while enabled and idle begins a conversion.
// - Completion sets the conversion complete flag and updates the result unless a low byte read has locked it.
// - The complete flag clears when the processor takes the matching interrupt vector.
// - Writing one to the flag clears it; writing zero leaves it unchanged.
// - Interrupt requested only while flag, interrupt enable and global enable are set.
// - Prescaler codes 000 and 001 divide by 2, then 4 up to 128.
// - After the low result byte is read, updates are blocked until high byte read.
// - Result right adjusted when left adjust is clear (reset), left adjusted when set.
// - The high result byte sits one register index (four byte addresses) above the low byte.
// - Free running mode restarts a conversion as soon as the previous one completes.
// - Trigger source 000 is free running, 001-111 peripheral flags; ignored when auto off.
package acr_pkg;
	// Register indices; byte address is four times the index.
	localparam logic [7:0] IDX_RES_LOW = 8'h78;
	localparam logic [7:0] IDX_RES_HIGH = 8'h79;
	localparam logic [7:0] IDX_CTRL_A = 8'h7A;
	localparam logic [7:0] IDX_CTRL_B = 8'h7B;
	localparam logic [7:0] IDX_SELECT = 8'h7C;
	localparam int ADDR_W = 12;
	// Control register A fields.
	localparam int CA_ENABLE = 7;
	localparam int CA_START = 6;
	localparam int CA_AUTO = 5;
	localparam int CA_FLAG = 4;
	localparam int CA_IRQ_EN = 3;
	localparam int CA_PS_LSB = 0;
	// Selection register fields.
	localparam int SEL_REF_LSB = 6;
	localparam int SEL_LEFT = 5;
	localparam int SEL_CHAN_LSB = 0;
	localparam int CB_TRIG_LSB = 0;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	// Conversion lengths in converter clock cycles.
	localparam logic [4:0] CONV_NORMAL_CYC = 5'd13;
	localparam logic [4:0] CONV_FIRST_CYC = 5'd25;
	localparam logic [3:0] CHAN_TEMP = 4'h8;
	localparam logic [2:0] TRIG_FREE_RUN = 3'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Settings and strobes presented to the analog core.
	typedef struct packed {
		logic power;
		logic temp_sensor_on;
		logic [1:0] reference_select;
		logic [3:0] channel_select;
		logic sample;
		logic conv_clk;
	} acr_ana_ctrl_t;

	// Division factor for a prescaler code.
	function automatic logic [7:0] acr_div_of(input logic [2:0] code);
		logic [7:0] d;
		d = 8'h02;
		if (code > 3'h1) begin
			d = 8'h01 << code;
		end
		return d;
	endfunction
endpackage

// ==== design/acr_prescale.sv ====
// Converter clock divider producing a tick and a clock level.
`timescale 1ns/1ps
`default_nettype none
module acr_prescale (
	// Clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// Control
	input wire logic run_i,
	input wire logic [2:0] code_i,
	// Outputs
	output logic tick_o,
	output logic conv_clk_o
);
	import acr_pkg::*;
	logic [7:0] cnt_ff;
	logic [7:0] div;

	assign div = acr_div_of(code_i);

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt_ff <= 8'h00;
			tick_o <= 1'b0;
			conv_clk_o <= 1'b0;
		end else if (!run_i) begin
			cnt_ff <= 8'h00;
			tick_o <= 1'b0;
			conv_clk_o <= 1'b0;
		end else begin
			tick_o <= (cnt_ff == div - 8'h01);
			conv_clk_o <= (cnt_ff < (div >> 1));
			cnt_ff <= (cnt_ff >= div - 8'h01) ? 8'h00 : cnt_ff + 8'h01;
		end
	end
endmodule
`default_nettype wire

// ==== design/acr_trig_sel.sv ====
// Auto trigger source selection and rising edge detection.
`timescale 1ns/1ps
`default_nettype none
module acr_trig_sel (
	// Clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// Control
	input wire logic auto_i,
	input wire logic [2:0] src_i,
	input wire logic [6:0] flags_i,
	// Output
	output logic edge_o
);
	import acr_pkg::*;
	logic level;
	logic prev_ff;

	assign level = (src_i == TRIG_FREE_RUN) ? 1'b0 : flags_i[src_i - 3'h1];

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			prev_ff <= 1'b0;
		end else begin
			prev_ff <= level;
		end
	end

	assign edge_o = auto_i && level && !prev_ff;
endmodule
`default_nettype wire

// ==== tb/acr_ana_model.sv ====
// Behavioural analog converter core facing the control block.
`timescale 1ns/1ps
`default_nettype none
module acr_ana_model
	import acr_pkg::*;
(
	input wire logic clk_i,
	input wire acr_ana_ctrl_t ctl_i,
	output logic [9:0] result_o
);
	logic [9:0] held = 10'h000;
	always @(posedge clk_i) begin
		if (ctl_i.sample) begin
			held <= {ctl_i.reference_select, ctl_i.channel_select, 4'hA};
		end
	end
	// An unpowered core drives the inverse.
	assign result_o = ctl_i.power ? held : ~held;
endmodule
`default_nettype wire

// ==== tb/acr_top_chk.sv ====
// Concurrent checks on the converter control block ports.
`timescale 1ns/1ps
`default_nettype none
module acr_top_chk
	import acr_pkg::*;
(
	input wire logic CORE_CLK_I,
	input wire logic ARST_N_I,
	input wire logic ARVALID_I,
	input wire logic ARREADY_O,
	input wire logic RVALID_O,
	input wire logic RREADY_I,
	input wire logic [31:0] RDATA_O,
	input wire logic BVALID_O,
	input wire logic BREADY_I,
	input wire logic [1:0] BRESP_O,
	input wire logic GLOBAL_IRQ_EN_I,
	input wire logic IRQ_O,
	input wire acr_ana_ctrl_t ANA_O
);
	default clocking cb @(posedge CORE_CLK_I);
	endclocking
	default disable iff (!ARST_N_I);
	irq_gate_a: assert property (IRQ_O |-> $past(GLOBAL_IRQ_EN_I))
		else $error("irq without global enable");
	b_hold_a: assert property (BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O))
		else $error("write response dropped");
	r_hold_a: assert property (RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O))
		else $error("read data dropped");
	r_answer_a: assert property (ARVALID_I && ARREADY_O |=> RVALID_O)
		else $error("read answer late");
	r_upper_a: assert property (RVALID_O |-> RDATA_O[31:8] == 24'h000000)
		else $error("read upper bits set");
	samp_pulse_a: assert property (ANA_O.sample |=> !ANA_O.sample)
		else $error("sample longer than one cycle");
	samp_power_a: assert property (ANA_O.sample |-> ANA_O.power)
		else $error("sample while unpowered");
	sel_hold_a: assert property (ANA_O.sample |=> ($stable(ANA_O.channel_select) || !ANA_O.power) [*8])
		else $error("channel changed mid conversion");
	temp_on_a: assert property (ANA_O.channel_select == CHAN_TEMP |-> ANA_O.temp_sensor_on)
		else $error("temperature sensor off");
	clk_idle_a: assert property (!ANA_O.power [*3] |-> !ANA_O.conv_clk)
		else $error("converter clock runs while unpowered");
	write_c: cover property (BVALID_O && BREADY_I);
	sample_c: cover property (ANA_O.sample);
	irq_c: cover property ($rose(IRQ_O));
endmodule
bind acr_top acr_top_chk u_chk (.CORE_CLK_I(CORE_CLK_I), .ARST_N_I(ARST_N_I), .ARVALID_I(ARVALID_I),
	.ARREADY_O(ARREADY_O), .RVALID_O(RVALID_O), .RREADY_I(RREADY_I), .RDATA_O(RDATA_O), .BVALID_O(BVALID_O),
	.BREADY_I(BREADY_I), .BRESP_O(BRESP_O), .GLOBAL_IRQ_EN_I(GLOBAL_IRQ_EN_I), .IRQ_O(IRQ_O), .ANA_O(ANA_O));
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import acr_pkg::*;
	logic clk = 1'b0, arst_n = 1'b0, gie = 1'b0, ack = 1'b0, irq_q = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h0;
	logic [6:0] trig = 7'h00;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [9:0] ana_res, rv;
	logic [7:0] g;
	acr_ana_ctrl_t ana;
	logic [34:0] notes[$];
	int fail_count = 0, checks_done = 0, cnt = 0, dur = 0, samples = 0;
	initial forever #2 clk = ~clk;
	acr_top dut (.CORE_CLK_I(clk), .ARST_N_I(arst_n), .AWVALID_I(awvalid), .AWREADY_O(awready),
		.AWADDR_I(awaddr), .WVALID_I(wvalid), .WREADY_O(wready), .WDATA_I(wdata), .WSTRB_I(4'hF),
		.BVALID_O(bvalid), .BREADY_I(bready), .BRESP_O(bresp), .ARVALID_I(arvalid), .ARREADY_O(arready),
		.ARADDR_I(araddr), .RVALID_O(rvalid), .RREADY_I(rready), .RDATA_O(rdata), .RRESP_O(rresp),
		.GLOBAL_IRQ_EN_I(gie), .IRQ_ACK_I(ack), .TRIG_FLAGS_I(trig), .IRQ_O(irq), .ANA_RESULT_I(ana_res),
		.ANA_O(ana));
	acr_ana_model u_ana (.clk_i(clk), .ctl_i(ana), .result_o(ana_res));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic complete_run();
		if (fail_count == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic stuck();
		fail_count++;
		complete_run();
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	function automatic logic [1:0] rsp_of(input logic [7:0] idx);
		return (idx >= IDX_RES_LOW && idx <= IDX_SELECT) ? RESP_OKAY : RESP_SLVERR;
	endfunction
	function automatic logic [9:0] res(input logic [1:0] r, input logic [3:0] c);
		return {r, c, 4'hA};
	endfunction
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		int n;
		@(posedge clk);
		notes.push_back({1'b0, rsp_of(idx), 32'h0});
		awaddr <= {2'b00, idx, 2'b00};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		if (n == 64) stuck();
	endtask
	task automatic rd(input logic [7:0] idx, input logic [8:0] exp, output logic [7:0] got);
		int n;
		@(posedge clk);
		notes.push_back({exp[8], rsp_of(idx), 24'h0, exp[7:0]});
		araddr <= {2'b00, idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		got = rdata[7:0];
		rready <= 1'b0;
		if (n == 64) stuck();
	endtask
	task automatic rres(input logic [9:0] r, input logic left);
		rd(IDX_RES_LOW, {1'b1, left ? {r[1:0], 6'h00} : r[7:0]}, g);
		rd(IDX_RES_HIGH, {1'b1, left ? r[9:2] : {6'h00, r[9:8]}}, g);
	endtask
	task automatic wait_irq();
		int n;
		for (n = 0; n < 4000 && !irq; n++) @(posedge clk);
		if (n == 4000) stuck();
	endtask
	task automatic conv(input logic [2:0] ps);
		wr(IDX_CTRL_A, {5'b11001, ps});
		rd(IDX_CTRL_A, {1'b1, 5'b11001, ps}, g);
		wait_irq();
		rd(IDX_CTRL_A, {1'b1, 5'b10011, ps}, g);
		wr(IDX_CTRL_A, {5'b10011, ps});
		tick(2);
		chk(32'(irq), 32'h0, "irq_clear");
	endtask
	always @(posedge clk) begin
		irq_q <= irq;
		cnt <= ana.sample ? 0 : cnt + 1;
		samples <= samples + int'(ana.sample);
		if (irq && !irq_q) dur <= cnt;
		if (((bvalid && bready) || (rvalid && rready)) && notes.size() > 0) begin
			chk(32'(bvalid ? bresp : rresp), 32'(notes[0][33:32]), "resp");
			if (notes[0][34]) chk(rdata, notes[0][31:0], "rdata");
			void'(notes.pop_front());
		end
	end
	initial begin
		logic [1:0] rf;
		logic [3:0] ch;
		int d0, df, s0, i, dv, x;
		void'($urandom(32'h500BA2B0));
		tick(20);
		arst_n <= 1'b1;
		for (i = 8'h78; i <= 8'h7D; i++) rd(8'(i), 9'h100, g);
		wr(8'h7D, 8'hFF);
		gie <= 1'b1;
		for (i = 0; i < 11; i++) begin
			ch = (i < 8) ? 4'(i) : (i == 8) ? 4'hE : (i == 9) ? 4'hF : CHAN_TEMP;
			rf = (i == 10) ? 2'h3 : 2'($urandom % 3);
			if (rf == 2'h2) rf = 2'h3;
			wr(IDX_SELECT, {rf, 2'b00, ch});
			rd(IDX_SELECT, {1'b1, rf, 2'b00, ch}, g);
			conv(3'h0);
			if (i == 0) df = dur;
			if (i == 1) d0 = dur;
			chk(32'({ana.reference_select, ana.channel_select, ana.temp_sensor_on}), 32'({rf, ch, ch == CHAN_TEMP}),
				"ana_sel");
			rres(res(rf, ch), 1'b0);
		end
		chk(32'(df - d0 >= 22 && df - d0 <= 26), 32'h1, "first_len");
		for (i = 0; i < 8; i++) begin
			conv(3'(i));
			if (i == 0) d0 = dur;
			dv = (i < 2) ? 2 : (1 << i);
			x = dur - d0 - 13 * (dv - 2);
			chk(32'(x >= -dv && x <= dv), 32'h1, "prescale");
		end
		rv = res(2'h3, 4'h8);
		wr(IDX_CTRL_A, 8'hC8);
		wr(IDX_SELECT, 8'hE8);
		rres(rv, 1'b1);
		wait_irq();
		wr(IDX_CTRL_A, 8'h98);
		wr(IDX_CTRL_A, 8'hC8);
		wr(IDX_SELECT, 8'h42);
		chk(32'(ana.channel_select), 32'h8, "chan_held");
		wait_irq();
		tick(2);
		chk(32'(ana.channel_select), 32'h2, "chan_new");
		wr(IDX_CTRL_A, 8'h98);
		rd(IDX_RES_LOW, {1'b1, rv[7:0]}, g);
		conv(3'h0);
		rd(IDX_RES_HIGH, {7'h40, rv[9:8]}, g);
		rres(rv, 1'b0);
		conv(3'h0);
		rres(res(2'h1, 4'h2), 1'b0);
		wr(IDX_CTRL_A, 8'hC8);
		wr(IDX_CTRL_A, 8'h08);
		tick(300);
		chk(32'({irq, ana.power}), 32'h0, "abort");
		rd(IDX_CTRL_A, 9'h108, g);
		gie <= 1'b0;
		wr(IDX_CTRL_A, 8'hC8);
		tick(300);
		chk(32'(irq), 32'h0, "irq_gated");
		gie <= 1'b1;
		tick(2);
		chk(32'(irq), 32'h1, "irq_on");
		ack <= 1'b1;
		tick(1);
		ack <= 1'b0;
		tick(2);
		chk(32'(irq), 32'h0, "irq_ack");
		rd(IDX_CTRL_A, 9'h188, g);
		wr(IDX_CTRL_B, 8'h00);
		s0 = samples;
		wr(IDX_CTRL_A, 8'hE0);
		tick(300);
		chk(32'(samples - s0 > 4), 32'h1, "free_run");
		wr(IDX_CTRL_A, 8'h10);
		for (i = 1; i < 8; i++) begin
			wr(IDX_CTRL_B, 8'(i));
			wr(IDX_CTRL_A, 8'h80);
			s0 = samples;
			trig <= 7'(1 << (i - 1));
			tick(100);
			chk(32'(samples - s0), 32'h0, "auto_off");
			trig <= 7'h00;
			wr(IDX_CTRL_A, 8'hB0);
			trig <= 7'(1 << (i - 1));
			tick(100);
			chk(32'(samples - s0), 32'h1, "auto_edge");
			trig <= 7'h00;
		end
		complete_run();
	end
endmodule
`default_nettype wire
